//--- diag_pkg.sv
// Notes on behaviour
// R1 - LLLL LLLL: full diagnosis, channels 1-8
// R2 - LLLL HHHH: full diagnosis, channels 9-16
// R3 - next frame shifts 16-bit diagnosis word out
// R4 - HHLL LLLL: input read-back, channels 1-8
// R5 - HHLL HHHH: input read-back, channels 9-16
// R6 - read-back frame: eight inputs plus diagnosis bits
// R7 - HLHL xxxx: SI looped to SO next frame; code decodes only HLHL LLLL and HLHL HHHH, other HLHL words give zeros
// R8 - echo never changes output states
// R9 - data byte ignored for these commands
// R10 - master runs further MSB-first frame to read
// R11 - HH normal, HL overload, LH open, LL short
// R12 - diagnosis of group clears after its read
// R13 - echo lasts one frame, next frame zeros
// R14 - unknown control word: next frame all zeros
`default_nettype none
package diag_pkg;
    localparam int FRAME_BITS = 16;
    localparam int CTRL_MSB = 15;
    localparam int CTRL_LSB = 8;
    localparam int CH_GROUP = 8;
    localparam int CHANNELS = 16;
    localparam logic [7:0] CMD_DIAG_LO = 8'h00;
    localparam logic [7:0] CMD_DIAG_HI = 8'h0F;
    localparam logic [7:0] CMD_RDBK_LO = 8'hC0;
    localparam logic [7:0] CMD_RDBK_HI = 8'hCF;
    localparam logic [7:0] CMD_ECHO_LO = 8'hA0;
    localparam logic [7:0] CMD_ECHO_HI = 8'hAF;
    // two-bit fault codes per channel, bit1 first on the wire
    localparam logic [1:0] DIAG_NORMAL = 2'h3;
    localparam logic [1:0] DIAG_OVERLOAD = 2'h2;
    localparam logic [1:0] DIAG_OPEN = 2'h1;
    localparam logic [1:0] DIAG_SHORT_GND = 2'h0;
    typedef enum logic [3:0] {
        RSP_ZERO = 4'b0001,
        RSP_DIAG = 4'b0010,
        RSP_RDBK = 4'b0100,
        RSP_ECHO = 4'b1000
    } rsp_mode_t;
endpackage
`default_nettype wire

//--- spi_diag_readout_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module spi_diag_readout_decoder (
    input wire logic mclk, // 40 MHz system clock
    input wire logic rst, // async reset, active high
    input wire logic cs_n, // spi chip select pin, active low
    input wire logic sclk, // spi clock pin
    input wire logic si, // spi serial data in pin
    output logic so, // spi serial data out
    output logic so_oe, // so driven while selected
    input wire logic [diag_pkg::CHANNELS-1:0] par_in, // parallel input pin levels
    input wire logic [2*diag_pkg::CHANNELS-1:0] fault_code, // live 2-bit code per channel
    output logic [diag_pkg::CHANNELS-1:0] diag_clr // one-cycle clear of latched faults
);
    import diag_pkg::*;

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic cs_sel_s;
    logic cs_n_s;
    logic sclk_s;
    logic si_s;
    logic [CHANNELS-1:0] par_in_s;
    // select is synchronised active high so that its reset value means idle
    sync2 u_sync_cs (.mclk(mclk), .rst(rst), .d(~cs_n), .q(cs_sel_s));
    assign cs_n_s = ~cs_sel_s;
    // sclk and si share one latency, so data lines up with its edge
    sync2 u_sync_clk (.mclk(mclk), .rst(rst), .d(sclk), .q(sclk_s));
    sync2 u_sync_si (.mclk(mclk), .rst(rst), .d(si), .q(si_s));

    // ****************************************
    // parallel input synchronisers
    // ****************************************
    // input pins are read only at frame start, but never raw
    for (genvar g = 0; g < CHANNELS; g++) begin : g_par_sync
        sync2 u_sync_par (.mclk(mclk), .rst(rst), .d(par_in[g]), .q(par_in_s[g]));
    end

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic cs_n_p;
        logic sclk_p;
        logic [FRAME_BITS-1:0] rx;
        logic [FRAME_BITS-1:0] tx;
        logic [4:0] nbits;
        rsp_mode_t mode;
        logic grp_hi;
        logic so;
        logic so_oe;
        logic [CHANNELS-1:0] clr;
    } dec_state_t;
    dec_state_t st_q;
    dec_state_t st_d;

    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic [7:0] ctrl;
    logic [15:0] word_diag;
    logic [15:0] word_rdbk;
    logic [7:0] grp_in;
    logic [15:0] grp_flt;
    rsp_mode_t cmd_mode;
    logic cmd_grp;

    // ****************************************
    // response words
    // ****************************************
    always_comb begin
        grp_in = st_q.grp_hi ? par_in_s[15:8] : par_in_s[7:0];
        grp_flt = st_q.grp_hi ? fault_code[31:16] : fault_code[15:0];
        word_diag = '0;
        word_rdbk = '0;
        for (int i = 0; i < CH_GROUP; i++) begin
            // channel 8 of group first (msb), two bits each
            word_diag[2*i +: 2] = grp_flt[2*i +: 2]; // R11 R3
            // input state then one fault bit: high means no fault
            word_rdbk[2*i+1] = grp_in[i]; // R6
            word_rdbk[2*i] = (grp_flt[2*i +: 2] == DIAG_NORMAL); // R6
        end
    end

    // ****************************************
    // command decode
    // ****************************************
    // only the control byte is looked at; the data byte is don't-care
    always_comb begin
        ctrl = st_q.rx[CTRL_MSB:CTRL_LSB]; // R9
        cmd_mode = RSP_ZERO;
        cmd_grp = 1'b0;
        case (ctrl)
            CMD_DIAG_LO: begin
                cmd_mode = RSP_DIAG; // R1
                cmd_grp = 1'b0;
            end
            CMD_DIAG_HI: begin
                cmd_mode = RSP_DIAG; // R2
                cmd_grp = 1'b1;
            end
            CMD_RDBK_LO: begin
                cmd_mode = RSP_RDBK; // R4
                cmd_grp = 1'b0;
            end
            CMD_RDBK_HI: begin
                cmd_mode = RSP_RDBK; // R5
                cmd_grp = 1'b1;
            end
            CMD_ECHO_LO: begin
                cmd_mode = RSP_ECHO; // R7 R8
                cmd_grp = 1'b0;
            end
            CMD_ECHO_HI: begin
                cmd_mode = RSP_ECHO; // R7 R8
                cmd_grp = 1'b1;
            end
            default: begin
                cmd_mode = RSP_ZERO; // R14
                cmd_grp = 1'b0;
            end
        endcase
    end

    // ****************************************
    // frame decode and shift
    // ****************************************
    always_comb begin
        st_d = st_q;
        st_d.cs_n_p = cs_n_s;
        st_d.sclk_p = sclk_s;
        st_d.clr = '0;
        cs_fall = st_q.cs_n_p & ~cs_n_s;
        cs_rise = ~st_q.cs_n_p & cs_n_s;
        sclk_rise = ~st_q.sclk_p & sclk_s & ~cs_n_s;
        sclk_fall = st_q.sclk_p & ~sclk_s & ~cs_n_s;
        if (cs_fall) begin
            st_d.nbits = '0;
            st_d.so_oe = 1'b1;
            case (st_q.mode)
                RSP_DIAG: begin
                    st_d.tx = word_diag; // R3
                    // latched faults of the group read now are released
                    st_d.clr = st_q.grp_hi ? 16'hFF00 : 16'h00FF; // R12
                end
                RSP_RDBK: begin
                    st_d.tx = word_rdbk; // R6
                end
                default: begin
                    st_d.tx = '0; // R13 R14
                end
            endcase
            st_d.so = (st_q.mode == RSP_ECHO) ? si_s : st_d.tx[FRAME_BITS-1]; // R7
        end else if (sclk_rise) begin
            st_d.rx = {st_q.rx[FRAME_BITS-2:0], si_s}; // R10
            if (st_q.nbits != 5'(FRAME_BITS)) begin
                st_d.nbits = st_q.nbits + 5'h1;
            end
        end else if (sclk_fall) begin
            st_d.tx = {st_q.tx[FRAME_BITS-2:0], 1'b0};
            if (st_q.mode != RSP_ECHO) begin
                st_d.so = st_q.tx[FRAME_BITS-2];
            end
        end
        // echo path follows si for the whole selected period only
        if (~cs_n_s && ~cs_fall && st_q.mode == RSP_ECHO) begin
            st_d.so = si_s; // R7
        end
        if (cs_rise) begin
            st_d.so_oe = 1'b0;
            st_d.so = 1'b0;
            // decode only whole frames; so and so_oe are cleared here
            if (st_q.nbits == 5'(FRAME_BITS)) begin
                // a known control byte picks the answer of the next frame
                st_d.mode = cmd_mode; // R1 R2 R4 R5 R7 R14
                st_d.grp_hi = cmd_grp;
            end else begin
                st_d.mode = RSP_ZERO; // R14
            end
            // an echo frame itself never re-arms the echo
            if (st_q.mode == RSP_ECHO) begin
                st_d.mode = RSP_ZERO; // R13
                st_d.grp_hi = st_q.grp_hi;
            end
        end
    end

    // ****************************************
    // state register
    // ****************************************
    // select idles high, so the previous-select bit resets high too
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_q <= '{
                cs_n_p: 1'b1,
                sclk_p: 1'b0,
                rx: '0,
                tx: '0,
                nbits: '0,
                mode: RSP_ZERO,
                grp_hi: 1'b0,
                so: 1'b0,
                so_oe: 1'b0,
                clr: '0
            };
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // every output is a register bit, never a gate after it
    assign so = st_q.so;
    assign so_oe = st_q.so_oe;
    assign diag_clr = st_q.clr;
endmodule // spi_diag_readout_decoder
`default_nettype wire

//--- spi_diag_readout_decoder_chk.sv
`timescale 1ns/1ps
`default_nettype none
module spi_diag_readout_decoder_chk (
    input wire logic mclk, // clock
    input wire logic rst, // reset
    input wire logic cs_n, // chip select
    input wire logic sclk, // spi clock
    input wire logic so, // serial out
    input wire logic so_oe, // out enable
    input wire logic [15:0] diag_clr // fault clear
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    AST_OE_OFF: assert property (cs_n [*6] |-> !so_oe) else $error("so_oe idle");
    AST_OE_ON: assert property (!cs_n [*6] |-> so_oe) else $error("so_oe off");
    AST_OE_CLK: assert property ($rose(sclk) |-> ##[1:4] so_oe) else $error("oe late");
    AST_SO_HOLD: assert property ((!cs_n && sclk) [*5] |-> $stable(so))
        else $error("so moved");
    AST_CLR_ONE: assert property (diag_clr != 16'h0000 |=> diag_clr == 16'h0000)
        else $error("clr long");
    AST_CLR_GRP: assert property (diag_clr != 16'h0000 |->
        diag_clr == 16'h00FF || diag_clr == 16'hFF00) else $error("clr group");
    AST_CLR_SEL: assert property (diag_clr != 16'h0000 |-> !cs_n)
        else $error("clr unselected");
    AST_CLR_IDLE: assert property (cs_n [*4] |-> diag_clr == 16'h0000)
        else $error("clr idle");
endmodule // spi_diag_readout_decoder_chk
bind spi_diag_readout_decoder spi_diag_readout_decoder_chk chk (.mclk(mclk), .rst(rst),
    .cs_n(cs_n), .sclk(sclk), .so(so), .so_oe(so_oe), .diag_clr(diag_clr));
`default_nettype wire

//--- spi_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
    input wire logic mclk, // clock
    input wire logic so, // serial out
    output logic cs_n, // chip select
    output logic sclk, // spi clock
    output logic si // serial in
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        si = 1'b0;
    end
    // one frame, msb first; so sampled just before each rising sclk
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        @(posedge mclk);
        cs_n <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            si <= tx[i];
            repeat (6) @(posedge mclk);
            rx[i] = so;
            sclk <= 1'b1;
            repeat (6) @(posedge mclk);
            sclk <= 1'b0;
        end
        repeat (6) @(posedge mclk);
        cs_n <= 1'b1;
        si <= ~tx[0];
        repeat (8) @(posedge mclk);
    endtask
endmodule // spi_master_model
`default_nettype wire

//--- sync2.sv
`timescale 1ns/1ps
`default_nettype none
module sync2 (
    input wire logic mclk, // system clock
    input wire logic rst, // async reset
    input wire logic d, // asynchronous input
    output logic q // synchronised level
);
    typedef struct packed {
        logic s1;
        logic s2;
    } sync_state_t;
    sync_state_t st_q;
    sync_state_t st_d;
    always_comb begin
        st_d.s1 = d;
        st_d.s2 = st_q.s1;
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign q = st_q.s2;
endmodule // sync2
`default_nettype wire

//--- test_spi_diag_readout_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module test_spi_diag_readout_decoder;
    import diag_pkg::*;
    logic mclk, rst, cs_n, sclk, si, so, so_oe;
    logic [15:0] par_in, diag_clr, rx;
    logic [31:0] fault_code;
    int num_errors = 0;
    int checked = 0;
    logic [15:0] clr_seen = 16'h0000;
    // keeps the last clear pulse that the block issued
    always @(posedge mclk) begin
        if (diag_clr != 16'h0000) begin
            clr_seen <= diag_clr;
        end
    end
    spi_diag_readout_decoder dut (.mclk(mclk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .si(si),
        .so(so), .so_oe(so_oe), .par_in(par_in), .fault_code(fault_code), .diag_clr(diag_clr));
    spi_master_model mst (.mclk(mclk), .so(so), .cs_n(cs_n), .sclk(sclk), .si(si));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    function automatic logic [15:0] rdbk(input int g);
        logic [15:0] w;
        for (int i = 0; i < 8; i++) begin
            w[2*i+1] = par_in[8*g+i];
            w[2*i] = fault_code[16*g+2*i +: 2] == DIAG_NORMAL;
        end
        return w;
    endfunction
    // each frame returns the answer to the frame before it
    task automatic t_diag();
        mst.xfer({CMD_DIAG_LO, 8'hA5}, rx);
        mst.xfer({CMD_DIAG_HI, 8'h3C}, rx);
        check(rx, 16'h1BE4);
        check(clr_seen, 16'h00FF);
        mst.xfer({CMD_RDBK_LO, 8'hFF}, rx);
        check(rx, 16'hE41B);
        check(clr_seen, 16'hFF00);
    endtask
    task automatic t_rdbk();
        mst.xfer({CMD_RDBK_HI, 8'h00}, rx);
        check(rx, rdbk(0));
        check(clr_seen, 16'hFF00);
        mst.xfer({CMD_ECHO_LO, 8'h77}, rx);
        check(rx, rdbk(1));
    endtask
    task automatic t_echo();
        mst.xfer({CMD_DIAG_LO, 8'h96}, rx);
        check(rx, {CMD_DIAG_LO, 8'h96});
        mst.xfer({CMD_ECHO_HI, 8'h0F}, rx);
        check(rx, 16'h0000);
        mst.xfer(16'h5A3C, rx);
        check(rx, 16'h5A3C);
        mst.xfer(16'h70FF, rx);
        check(rx, 16'h0000);
    endtask
    task automatic t_bad();
        mst.xfer({CMD_DIAG_HI, 8'h00}, rx);
        check(rx, 16'h0000);
        mst.xfer({CMD_DIAG_HI, 8'h00}, rx);
        check(rx, 16'hE41B);
    endtask
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        print_verdict();
    end
    initial begin
        rst = 1'b1;
        par_in = 16'h5AC3;
        fault_code = 32'hE41B_1BE4;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        t_diag();
        t_rdbk();
        t_echo();
        t_bad();
        print_verdict();
    end
endmodule // test_spi_diag_readout_decoder
`default_nettype wire
